// >>> verilog/stpi_regs.svh
// register map, field positions and sizes of the transmit input port
// assumes inclusion by stpi_pkg users and the top module only
`ifndef STPI_REGS_SVH
`define STPI_REGS_SVH
`define STPI_OFS_CTRL     12'h000
`define STPI_OFS_STATUS   12'h004
`define STPI_OFS_ISR      12'h008
`define STPI_OFS_IMR      12'h00C
`define STPI_CTRL_RST     2'h0
`define STPI_CTRL_ENA     0
`define STPI_CTRL_RESUME  1
`define STPI_IMR_RST      4'h0
`define STPI_EV_WRITE     0
`define STPI_EV_OVFL      1
`define STPI_EV_IRQREQ    2
`define STPI_EV_PAUSE     3
`define STPI_DEPTH        256
`define STPI_PTR_W        8
`define STPI_CNT_W        9
`define STPI_HALF         9'h080
`define STPI_CHAR_W       14
`define STPI_BIT_QUAL     12
`define STPI_LEN_W        4
`define STPI_LEN_8        4'h8
`define STPI_LEN_10       4'hA
`define STPI_LEN_12       4'hC
`define STPI_SYNC_W       23
`endif

// >>> verilog/stpi_pkg.sv
// types shared by the transmit input port
// assumes stpi_regs.svh for all numeric constants
`default_nettype none
package stpi_pkg;
	typedef enum logic [3:0] {
		STPI_ENC8  = 4'b0001,
		STPI_PRE10 = 4'b0010,
		STPI_ENC10 = 4'b0100,
		STPI_PRE12 = 4'b1000
	} stpi_mode_t;
	typedef enum logic [2:0] {
		STPI_RD_IDLE  = 3'b001,
		STPI_RD_SHIFT = 3'b010,
		STPI_RD_PAUSE = 3'b100
	} stpi_rd_t;
endpackage
`default_nettype wire

// >>> verilog/stpi_top.sv
// transmit host input port: pin capture, 256-entry transmit FIFO,
// NRZ shifter and APB register slave with a level interrupt
// assumes pins and both pin clocks are slow against clk_sys (250 MHz)
//
// Function
// [RQ1] two pins pick one of four codings
// [RQ2] encoded 8-bit FIFO: bit8 irq, bit9 pause
// [RQ3] bits 10/11 violation and cell start flags
// [RQ4] pre-encoded bits leave LSB first, NRZ
// [RQ5] capture bus and qualifier on sample edge
// [RQ6] convention pin sets enable and flag polarity
// [RQ7] clocking mode from range, speed, bypass
// [RQ8] bypass low: reference clock runs everything
// [RQ9] bypass high: host clock writes FIFO
// [RQ10] bus timing: flags and enable active low
// [RQ11] selected by match, write while enabled
// [RQ12] cascade timing: flags and enable active high
// [RQ13] cascade writes data one cycle later
// [RQ14] external FIFO may feed cascade input
// [RQ15] FIFO holds 256 characters of 14 bits
// [RQ16] full, half and empty flags, host clocked
// [RQ17] sync host writes at character rate
// [RQ18] host must not write while full
//
// Chosen here: register access over APB and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "stpi_regs.svh"
module stpi_top (
	input  wire logic        clk_sys,              // 250 MHz system clock
	input  wire logic        reset,                // synchronous, active high
	input  wire logic        psel,                 // apb select
	input  wire logic        penable,              // apb access phase
	input  wire logic        pwrite,               // apb direction
	input  wire logic [11:0] paddr,                // apb byte address
	input  wire logic [31:0] pwdata,               // apb write data
	output logic      [31:0] prdata,               // apb read data
	output logic             pready,               // apb ready
	output logic             pslverr,              // apb error, unmapped
	input  wire logic        host_write_clk,       // host write clock pin
	input  wire logic        ref_clk_a,            // reference clock pin
	input  wire logic [11:0] tx_in_bus,            // transmit input bus
	input  wire logic        tx_cmd_data_qual,     // command/data qualifier
	input  wire logic        tx_write_en,          // write enable, polarity per convention
	input  wire logic        addr_match_n,         // address match, low selects
	input  wire logic        encoder_bypass_n,     // coding mode pin
	input  wire logic        char_width_sel,       // character width pin
	input  wire logic        fifo_bypass_n,        // low: synchronous mode
	input  wire logic        iface_convention_sel, // high: cascade timing
	input  wire logic        freq_range_sel,       // range select
	input  wire logic        speed_sel,            // speed select
	output logic             tx_fifo_empty_flag,   // empty, polarity per convention
	output logic             tx_fifo_full_flag,    // full, polarity per convention
	output logic             tx_fifo_half_flag,    // half full, polarity per convention
	output logic             tx_ser,               // serial NRZ bit
	output logic             irq                   // level interrupt
);
	import stpi_pkg::*;

	logic [`STPI_SYNC_W-1:0] s1_q, s2_q;
	logic                    hclk_q, rclk_q;
	always_ff @(posedge clk_sys) begin
		s1_q <= {host_write_clk, ref_clk_a, tx_in_bus, tx_cmd_data_qual, tx_write_en,
			addr_match_n, encoder_bypass_n, char_width_sel, fifo_bypass_n,
			iface_convention_sel, freq_range_sel, speed_sel};
		s2_q <= s1_q;
		hclk_q <= s2_q[22];
		rclk_q <= s2_q[21];
	end
	// data crosses through the same two stages as the clocks, so they stay aligned
	wire logic [11:0] bus_s  = s2_q[20:9];
	wire logic        qual_s = s2_q[8];
	wire logic        en_s   = s2_q[7];
	wire logic        am_n_s = s2_q[6];
	wire logic        encb_s = s2_q[5];
	wire logic        cw_s   = s2_q[4];
	wire logic        fifo_s = s2_q[3];
	wire logic        conv_s = s2_q[2];
	wire logic [2:0]  clkm_s = {fifo_s, s2_q[1], s2_q[0]};       // see [RQ7]
	wire logic        hrise  = s2_q[22] & ~hclk_q;
	wire logic        rrise  = s2_q[21] & ~rclk_q;
	wire logic        srise  = fifo_s ? hrise : rrise;            // see [RQ8] see [RQ9]
	wire logic        en_act = conv_s ? en_s : ~en_s;             // see [RQ10] see [RQ12]

	stpi_mode_t mode;
	always_comb begin
		case ({encb_s, cw_s})                                     // see [RQ1]
			2'b11:   mode = STPI_ENC8;
			2'b01:   mode = STPI_PRE10;
			2'b10:   mode = STPI_ENC10;
			default: mode = STPI_PRE12;
		endcase
	end

	// mask per coding mode; open cells of the map read as zero
	logic [`STPI_CHAR_W-1:0] chr;
	always_comb begin
		chr = '0;
		chr[7:0] = bus_s[7:0];
		case (mode)
			STPI_ENC8: begin
				chr[9:8] = fifo_s ? bus_s[9:8] : 2'b00;           // see [RQ2]
				chr[10] = bus_s[10];                              // see [RQ3]
				chr[11] = fifo_s & bus_s[11];
				chr[`STPI_BIT_QUAL] = qual_s;
			end
			STPI_ENC10: begin
				chr[9:8] = bus_s[9:8];
				chr[10] = bus_s[10];                              // see [RQ3]
				chr[11] = fifo_s & bus_s[11];
				chr[`STPI_BIT_QUAL] = qual_s;
			end
			STPI_PRE10: chr[9:8] = bus_s[9:8];                    // see [RQ3]
			default:    chr[11:8] = bus_s[11:8];
		endcase
	end

	// selection and write strobe
	logic sel_q, dwr_q;
	logic [`STPI_CHAR_W-1:0] sync_q;
	logic                    sync_v_q;
	wire logic sel_d = en_act & (sel_q | ~am_n_s);                // see [RQ11]
	wire logic wr    = srise & (conv_s ? dwr_q : (sel_q & en_act)); // see [RQ13] see [RQ5]
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			sel_q <= 1'b0;
			dwr_q <= 1'b0;
		end else if (srise) begin
			sel_q <= sel_d;
			dwr_q <= sel_d;                                       // see [RQ13]
		end
	end

	// FIFO, single clk_sys domain; host edges act only as write events
	logic [`STPI_CHAR_W-1:0] mem [`STPI_DEPTH];                   // see [RQ15]
	logic [`STPI_PTR_W-1:0]  wp_q, rp_q;
	logic [`STPI_CNT_W-1:0]  cnt_q;
	wire logic full  = cnt_q == `STPI_CNT_W'(`STPI_DEPTH);
	wire logic empty = cnt_q == '0;
	wire logic fwr   = wr & fifo_s & ~full;                       // see [RQ18]
	logic rd;
	always_ff @(posedge clk_sys) begin
		if (fwr) begin
			mem[wp_q] <= chr;
		end
	end
	always_ff @(posedge clk_sys) begin
		if (reset | ~fifo_s) begin
			wp_q <= '0;
			rp_q <= '0;
			cnt_q <= '0;
		end else begin
			wp_q <= wp_q + `STPI_PTR_W'(fwr);
			rp_q <= rp_q + `STPI_PTR_W'(rd);
			cnt_q <= cnt_q + `STPI_CNT_W'(fwr) - `STPI_CNT_W'(rd);
		end
	end
	// flags follow the host write domain: updated on host clock edges, every cycle when fifo_s is low
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			tx_fifo_empty_flag <= 1'b0;
			tx_fifo_full_flag <= 1'b0;
			tx_fifo_half_flag <= 1'b0;
		end else if (hrise | ~fifo_s) begin                       // see [RQ16]
			tx_fifo_empty_flag <= conv_s ? empty : ~empty;        // see [RQ6]
			tx_fifo_full_flag <= conv_s ? full : ~full;
			tx_fifo_half_flag <= conv_s ? (cnt_q >= `STPI_HALF) : (cnt_q < `STPI_HALF);
		end
	end

	// synchronous mode pipeline register, reference clocked
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			sync_q <= '0;
			sync_v_q <= 1'b0;
		end else if (wr & ~fifo_s) begin                          // see [RQ8]
			sync_q <= chr;
			sync_v_q <= 1'b1;
		end else if (rd) begin
			sync_v_q <= 1'b0;
		end
	end

	// shifter: one bit per reference edge, bit 0 first
	stpi_rd_t                st_q;
	logic [`STPI_CHAR_W-1:0] sh_q;
	logic [`STPI_LEN_W-1:0]  left_q;
	logic                    pause_q, ena_q, resume_q;
	logic [3:0]              ev;
	wire logic [`STPI_CHAR_W-1:0] nxt = fifo_s ? mem[rp_q] : sync_q;
	wire logic avail = fifo_s ? ~empty : sync_v_q;
	wire logic [`STPI_LEN_W-1:0] len = (mode == STPI_PRE12) ? `STPI_LEN_12 :
		(mode == STPI_ENC8) ? `STPI_LEN_8 : `STPI_LEN_10;
	assign rd = rrise & ena_q & avail & ~pause_q &
		(st_q == STPI_RD_IDLE || (st_q == STPI_RD_SHIFT && left_q == `STPI_LEN_W'(1)));
	wire logic ctl_en = (mode == STPI_ENC8) & fifo_s;            // see [RQ2]
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			st_q <= STPI_RD_IDLE;
			sh_q <= '0;
			left_q <= '0;
			tx_ser <= 1'b0;
		end else begin
			case (st_q)
				STPI_RD_IDLE: begin
					if (pause_q) begin
						st_q <= STPI_RD_PAUSE;
					end else if (rd) begin
						sh_q <= nxt;
						left_q <= len;
						st_q <= STPI_RD_SHIFT;
					end
				end
				STPI_RD_SHIFT: begin
					if (rrise) begin
						tx_ser <= sh_q[0];                        // see [RQ4]
						if (rd) begin
							sh_q <= nxt;
							left_q <= len;
						end else begin
							sh_q <= sh_q >> 1;
							left_q <= left_q - `STPI_LEN_W'(1);
							if (left_q == `STPI_LEN_W'(1)) begin
								st_q <= STPI_RD_IDLE;
							end
						end
					end
				end
				STPI_RD_PAUSE: begin
					if (!pause_q) begin
						st_q <= STPI_RD_IDLE;
					end
				end
				default: st_q <= STPI_RD_IDLE;
			endcase
		end
	end
	// pause holds the reader until software resumes; set beats resume
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			pause_q <= 1'b0;
		end else if (rd & ctl_en & ~nxt[9]) begin                 // see [RQ2]
			pause_q <= 1'b1;
		end else if (resume_q) begin
			pause_q <= 1'b0;
		end
	end

	assign ev[`STPI_EV_WRITE]  = wr;
	assign ev[`STPI_EV_OVFL]   = wr & fifo_s & full;
	assign ev[`STPI_EV_IRQREQ] = rd & ctl_en & nxt[8];
	assign ev[`STPI_EV_PAUSE]  = rd & ctl_en & ~nxt[9];

	// apb slave: ready in the access cycle, data registered in setup
	logic [3:0] isr_q, imr_q;
	wire logic setup = psel & ~penable;
	wire logic done  = psel & penable & pready;
	wire logic a_ctl = paddr == `STPI_OFS_CTRL;
	wire logic a_sts = paddr == `STPI_OFS_STATUS;
	wire logic a_isr = paddr == `STPI_OFS_ISR;
	wire logic a_imr = paddr == `STPI_OFS_IMR;
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= '0;
		end else begin
			pready <= setup;
			pslverr <= setup & ~(a_ctl | a_sts | a_isr | a_imr);
			if (setup & ~pwrite) begin
				if (a_ctl) begin
					prdata <= {31'h0000_0000, ena_q};
				end else if (a_sts) begin
					prdata <= {9'h000, st_q, clkm_s, mode, sel_q, pause_q,
						cnt_q, full, empty};
				end else if (a_isr) begin
					prdata <= {28'h000_0000, isr_q};
				end else if (a_imr) begin
					prdata <= {28'h000_0000, imr_q};
				end else begin
					prdata <= '0;
				end
			end
		end
	end
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			{resume_q, ena_q} <= `STPI_CTRL_RST;
			imr_q <= `STPI_IMR_RST;
		end else begin
			resume_q <= done & pwrite & a_ctl & pwdata[`STPI_CTRL_RESUME];
			if (done & pwrite & a_ctl) begin
				ena_q <= pwdata[`STPI_CTRL_ENA];
			end
			if (done & pwrite & a_imr) begin
				imr_q <= pwdata[3:0];
			end
		end
	end
	// read clears the status, a same-cycle event survives
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			isr_q <= '0;
			irq <= 1'b0;
		end else begin
			isr_q <= ((done & ~pwrite & a_isr) ? 4'h0 : isr_q) | ev;
			irq <= |(isr_q & imr_q);
		end
	end

	// checks
	property p_bus_wr;
		@(posedge clk_sys) disable iff (reset)
		(wr & ~conv_s) |-> (sel_q & ~en_s);
	endproperty
	a_bus_wr: assert property (p_bus_wr) else $error("bus write without selection"); // see [RQ11]
	// remembers a cascade request up to the next sample edge, however far away
	logic cas_pend_q;
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			cas_pend_q <= 1'b0;
		end else if (srise) begin
			cas_pend_q <= conv_s & sel_d;
		end
	end
	sequence s_cas_due;
		srise & conv_s & cas_pend_q;
	endsequence
	property p_cas_delay;
		@(posedge clk_sys) disable iff (reset)
		s_cas_due |-> wr;
	endproperty
	a_cas_delay: assert property (p_cas_delay) else $error("cascade write not delayed"); // see [RQ13]
	property p_flag_pol;
		@(posedge clk_sys) disable iff (reset)
		(~$past(reset) & $past(hrise) & $past(fifo_s) & $past(conv_s) & conv_s) |->
			tx_fifo_empty_flag == $past(empty);
	endproperty
	a_flag_pol: assert property (p_flag_pol) else $error("empty flag polarity wrong"); // see [RQ12]
	property p_flag_low;
		@(posedge clk_sys) disable iff (reset)
		(~$past(reset) & $past(hrise) & $past(fifo_s) & ~$past(conv_s)) |->
			tx_fifo_full_flag == ~$past(full);
	endproperty
	a_flag_low: assert property (p_flag_low) else $error("full flag polarity wrong"); // see [RQ10]
	property p_depth;
		@(posedge clk_sys) disable iff (reset)
		cnt_q <= `STPI_CNT_W'(`STPI_DEPTH);
	endproperty
	a_depth: assert property (p_depth) else $error("fifo count past depth"); // see [RQ15]
	property p_no_ovwr;
		@(posedge clk_sys) disable iff (reset)
		(full & ~rd & fifo_s & $stable(fifo_s)) |=> $stable(cnt_q);
	endproperty
	a_no_ovwr: assert property (p_no_ovwr) else $error("write stored while full"); // see [RQ18]
	property p_sync_path;
		@(posedge clk_sys) disable iff (reset)
		(wr & ~fifo_s) |=> (sync_q == $past(chr)) & sync_v_q;
	endproperty
	a_sync_path: assert property (p_sync_path) else $error("sync capture lost"); // see [RQ8]
	property p_lsb_first;
		@(posedge clk_sys) disable iff (reset)
		((st_q == STPI_RD_SHIFT) & rrise) |=> tx_ser == $past(sh_q[0]);
	endproperty
	a_lsb_first: assert property (p_lsb_first) else $error("serial order wrong"); // see [RQ4]
	property p_mask;
		@(posedge clk_sys) disable iff (reset)
		(mode != STPI_PRE12) |-> chr[11:10] == (mode == STPI_PRE10 ? 2'b00 :
			{fifo_s & bus_s[11], bus_s[10]});
	endproperty
	a_mask: assert property (p_mask) else $error("flag bits mis-mapped"); // see [RQ3]
	property p_pause;
		@(posedge clk_sys) disable iff (reset)
		(rd & ctl_en & ~nxt[9]) |=> pause_q ##1 ~rd;
	endproperty
	a_pause: assert property (p_pause) else $error("pause request ignored"); // see [RQ2]
endmodule
`default_nettype wire

// >>> verif/stpi_host_model.sv
// host side of the transmit input port: a bus master writing bursts
// assumes clk_sys paces it; host clock stands still between bursts
`timescale 1ns/1ps
`default_nettype none
module stpi_host_model (
	input  wire logic        clk_sys,          // paces the host clock
	input  wire logic        conv_sel,         // high: cascade levels
	output logic             host_write_clk,   // host write clock
	output logic [11:0]      tx_in_bus,        // character bits
	output logic             tx_cmd_data_qual, // qualifier
	output logic             tx_write_en,      // polarity per convention
	output logic             addr_match_n      // low selects
);
	logic busy;
	logic en_q;
	initial begin
		host_write_clk = 1'b0;
		tx_in_bus = 12'h000;
		tx_cmd_data_qual = 1'b0;
		addr_match_n = 1'b1;
		busy = 1'b0;
		en_q = 1'b1;
	end
	assign tx_write_en = busy ? en_q : ~conv_sel;
	// one 40 ns host period, far below the 50 MHz limit
	task edge2;
		repeat (5) @(posedge clk_sys);
		host_write_clk <= 1'b1;
		repeat (5) @(posedge clk_sys);
		host_write_clk <= 1'b0;
	endtask
	// rise 0 selects; cascade drops enable at the rise that carries the last data
	task send(input int n, input logic [11:0] d0, input logic q);
		@(posedge clk_sys);
		busy <= 1'b1;
		tx_cmd_data_qual <= q;
		for (int k = 0; k <= n; k++) begin
			en_q <= (k < n || !conv_sel) ? conv_sel : ~conv_sel;
			addr_match_n <= (k != 0);
			tx_in_bus <= (k == 0) ? ~d0 : d0 + 12'(k - 1);
			edge2();
		end
		en_q <= ~conv_sel;
		addr_match_n <= 1'b1;
		tx_in_bus <= ~tx_in_bus;
		tx_cmd_data_qual <= ~q;
		edge2();
		busy <= 1'b0;
	endtask
endmodule
`default_nettype wire

// >>> verif/serial_transmit_host_input_port_bench.sv
// self-checking bench: apb master, host model, free reference clock
// assumes stpi_top and stpi_host_model; one scenario per task
`timescale 1ns/1ps
`default_nettype none
`include "stpi_regs.svh"
module serial_transmit_host_input_port_bench;
	import stpi_pkg::*;
	logic        clk_sys, reset, psel, penable, pwrite, pready, pslverr;
	logic [11:0] paddr, bus;
	logic [31:0] pwdata, prdata, st;
	logic        hclk, ref_clk_a, qual, wen, am_n, byp_n, wid, fifo_n, conv;
	logic        rng, spd, efl, ffl, hfl, tx_ser, irq;
	logic [2:0]  rdiv;
	int          error_cnt, checked;
	stpi_top dut (.clk_sys(clk_sys), .reset(reset), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .host_write_clk(hclk), .ref_clk_a(ref_clk_a), .tx_in_bus(bus),
		.tx_cmd_data_qual(qual), .tx_write_en(wen), .addr_match_n(am_n),
		.encoder_bypass_n(byp_n), .char_width_sel(wid), .fifo_bypass_n(fifo_n),
		.iface_convention_sel(conv), .freq_range_sel(rng), .speed_sel(spd),
		.tx_fifo_empty_flag(efl), .tx_fifo_full_flag(ffl), .tx_fifo_half_flag(hfl),
		.tx_ser(tx_ser), .irq(irq));
	stpi_host_model host (.clk_sys(clk_sys), .conv_sel(conv), .host_write_clk(hclk),
		.tx_in_bus(bus), .tx_cmd_data_qual(qual), .tx_write_en(wen), .addr_match_n(am_n));
	initial begin
		clk_sys = 1'b0;
		forever #2 clk_sys = ~clk_sys;
	end
	always @(posedge clk_sys) begin
		rdiv <= (rdiv == 3'h4) ? 3'h0 : rdiv + 3'h1;
		if (rdiv == 3'h4) ref_clk_a <= ~ref_clk_a;
	end
	task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		checked++;
		if (got !== exp) begin
			error_cnt++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
		output logic [31:0] rd, output logic err);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge clk_sys);
		penable <= 1'b1;
		@(posedge clk_sys);
		// no cycle count assumed; only the watchdog ends a stuck wait
		while (pready !== 1'b1) begin
			@(posedge clk_sys);
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		// idle edge, so a following call never reassigns psel in the same step
		@(posedge clk_sys);
	endtask
	task rd(input logic [11:0] a, output logic [31:0] d);
		logic e;
		apb(1'b0, a, 32'h0000_0000, d, e);
	endtask
	task wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] x;
		logic        e;
		apb(1'b1, a, d, x, e);
	endtask
	task cfg(input logic b, input logic w, input logic c);
		byp_n <= b;
		wid <= w;
		conv <= c;
		reset <= 1'b1;
		repeat (16) @(posedge clk_sys);
		reset <= 1'b0;
		@(posedge clk_sys);
	endtask
	task s_regs;
		logic [31:0] d;
		logic        e;
		rd(`STPI_OFS_CTRL, d);
		chk("ctrl reset", 32'h0000_0000, d);
		rd(`STPI_OFS_IMR, d);
		chk("imr reset", 32'h0000_0000, d);
		apb(1'b0, 12'h010, 32'h0000_0000, d, e);
		chk("unmapped err", 32'h0000_0001, {31'h0, e});
		chk("unmapped data", 32'h0000_0000, d);
	endtask
	task s_modes;
		logic [3:0] mt [4];
		mt = '{STPI_ENC8, STPI_PRE10, STPI_ENC10, STPI_PRE12};
		for (int i = 0; i < 4; i++) begin
			byp_n <= ~i[0];
			wid <= ~i[1];
			rng <= i[0];
			spd <= i[1];
			repeat (8) @(posedge clk_sys);
			rd(`STPI_OFS_STATUS, st);
			chk("coding mode", {28'h0, mt[i]}, {28'h0, st[16:13]});
			chk("clock mode", {29'h0, 1'b1, i[0], i[1]}, {29'h0, st[19:17]});
		end
	endtask
	task s_bus;
		logic [31:0] d;
		cfg(1'b1, 1'b0, 1'b0);
		wr(`STPI_OFS_IMR, 32'h0000_0001);
		host.send(3, 12'h3A5, 1'b1);
		rd(`STPI_OFS_STATUS, st);
		chk("bus count", 32'h0000_0003, {23'h0, st[10:2]});
		chk("bus flags", 32'h0000_0003, {30'h0, ffl, efl});
		chk("irq up", 32'h0000_0001, {31'h0, irq});
		rd(`STPI_OFS_ISR, d);
		chk("write event", 32'h0000_0001, {31'h0, d[0]});
		repeat (3) @(posedge clk_sys);
		chk("irq down", 32'h0000_0000, {31'h0, irq});
		rd(`STPI_OFS_ISR, d);
		chk("event cleared", 32'h0000_0000, {31'h0, d[0]});
	endtask
	task s_casc;
		cfg(1'b1, 1'b0, 1'b1);
		host.send(2, 12'h155, 1'b0);
		rd(`STPI_OFS_STATUS, st);
		chk("cascade count", 32'h0000_0002, {23'h0, st[10:2]});
		chk("cascade flags", 32'h0000_0000, {30'h0, ffl, efl});
	endtask
	// f low: reference-clocked pipeline register, f high: FIFO path
	task s_drain(input logic f);
		logic [31:0] sh;
		int          k;
		fifo_n <= f;
		cfg(1'b0, 1'b0, 1'b0);
		host.send(1, 12'hB35, 1'b0);
		wr(`STPI_OFS_CTRL, 32'h0000_0001);
		for (int i = 0; i < 32; i++) begin
			@(negedge ref_clk_a);
			sh[i] = tx_ser;
		end
		k = 0;
		while (k < 20 && sh[k] !== 1'b1) k++;
		chk("serial order", 32'h0000_0B35, {20'h0, sh[k +: 12]});
		rd(`STPI_OFS_STATUS, st);
		chk("drained", 32'h0000_0000, {23'h0, st[10:2]});
	endtask
	// encoded 8-bit FIFO character with interrupt request set and pause low
	task s_pause;
		logic [31:0] d;
		cfg(1'b1, 1'b1, 1'b0);
		wr(`STPI_OFS_IMR, 32'h0000_000C);
		host.send(1, 12'h1A5, 1'b0);
		wr(`STPI_OFS_CTRL, 32'h0000_0001);
		repeat (40) @(posedge clk_sys);
		chk("control irq", 32'h0000_0001, {31'h0, irq});
		rd(`STPI_OFS_ISR, d);
		chk("control events", 32'h0000_0003, {30'h0, d[3:2]});
		rd(`STPI_OFS_STATUS, st);
		chk("paused", 32'h0000_0001, {31'h0, st[11]});
		wr(`STPI_OFS_CTRL, 32'h0000_0003);
		repeat (2) @(posedge clk_sys);
		rd(`STPI_OFS_STATUS, st);
		chk("resumed", 32'h0000_0000, {31'h0, st[11]});
	endtask
	task s_fill;
		logic [31:0] d;
		cfg(1'b1, 1'b0, 1'b0);
		wr(`STPI_OFS_IMR, 32'h0000_0002);
		host.send(257, 12'h000, 1'b0);
		rd(`STPI_OFS_STATUS, st);
		chk("fill count", 32'h0000_0100, {23'h0, st[10:2]});
		chk("full flags", 32'h0000_0001, {29'h0, hfl, ffl, efl});
		chk("overflow irq", 32'h0000_0001, {31'h0, irq});
		rd(`STPI_OFS_ISR, d);
		chk("overflow event", 32'h0000_0001, {31'h0, d[1]});
	endtask
	task summarize;
		$display("checks %0d errors %0d", checked, error_cnt);
		if (error_cnt == 0 && checked > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge clk_sys);
		error_cnt++;
		$display("MISMATCH watchdog expected done seen hang");
		summarize();
	end
	initial begin
		{reset, psel, penable, pwrite, ref_clk_a, byp_n, wid, conv, rng, spd} = 10'h200;
		{fifo_n, paddr, pwdata, rdiv, error_cnt, checked} = {1'b1, 12'h000, 32'h0, 3'h0, 64'h0};
		repeat (16) @(posedge clk_sys);
		reset <= 1'b0;
		@(posedge clk_sys);
		s_regs();
		s_modes();
		s_bus();
		s_casc();
		s_drain(1'b0);
		s_drain(1'b1);
		s_pause();
		s_fill();
		summarize();
	end
endmodule
`default_nettype wire
